// file: pscb_pkg.sv
// Purpose: Shared constants and types for the status and buck control bank
// Assumes: 8-bit registers on an internal register port
// Notes: Reset codes for the controller registers come from parameters
package pscb_pkg;
  localparam logic [7:0] PSCB_ADDR_DIE_TEMP = 8'h04;
  localparam logic [7:0] PSCB_ADDR_SHDN_CAUSE = 8'h05;
  localparam logic [7:0] PSCB_ADDR_CTRL1 = 8'h20;
  localparam logic [7:0] PSCB_ADDR_CTRL2 = 8'h21;
  localparam logic [7:0] PSCB_ADDR_CTRL3 = 8'h22;
  localparam logic [7:0] PSCB_ADDR_IRQ = 8'h02;
  localparam logic [7:0] PSCB_ADDR_FAULT1 = 8'hB2;
  localparam logic [7:0] PSCB_ADDR_FAULT2 = 8'hB3;
  localparam int PSCB_BIT_DIE_HOT = 0;
  localparam int PSCB_BIT_CRIT = 0;
  localparam int PSCB_BIT_RAIL = 1;
  localparam int PSCB_BIT_UV = 2;
  localparam int PSCB_BIT_COLD = 3;
  localparam int PSCB_BIT_SHDN_EVT = 3;
  localparam int PSCB_BIT_DECAY = 0;
  localparam logic [3:0] PSCB_CAUSE_RESET = 4'h0;
  localparam logic [7:0] PSCB_ZERO8 = 8'h00;
  localparam logic [6:0] PSCB_ZERO7 = 7'h00;
  localparam logic [15:0] PSCB_ZERO16 = 16'h0000;
  localparam logic [3:0] PSCB_ZERO4 = 4'h0;
  localparam int PSCB_BYTE_W = 8;
  localparam int PSCB_CAUSE_W = 4;
  localparam int PSCB_MAP_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pscb_req_t;

  typedef struct packed {
    logic [6:0] code;
    logic decay_passive;
  } pscb_ctrl_t;

  typedef struct packed {
    logic critical_heat;
    logic rail_fault;
    logic supply_undervoltage;
    logic [15:0] rail_fault_map;
  } pscb_event_t;
endpackage : pscb_pkg

// file: pscb_ctrl_reg.sv
// Purpose: One controller voltage-code and decay-mode register
// Assumes: Write strobe already decoded for this register
// Notes: Reports a downward code move and how it should be carried out
`timescale 1ns/1ps
module pscb_ctrl_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output pscb_pkg::pscb_ctrl_t ctrl_out,
  output logic slew_down_out,
  output logic decay_down_out
);
  import pscb_pkg::*;
  pscb_ctrl_t ctrl;
  pscb_ctrl_t next_ctrl;
  logic going_down;
  assign next_ctrl = wr_in ? pscb_ctrl_t'(wdata_in) : ctrl;
  // Lower code only; decay bit taken from the same write, not the stored one
  assign going_down = wr_in && (wdata_in[7:1] < ctrl.code);
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl <= pscb_ctrl_t'(RESET_VALUE);
      slew_down_out <= 1'b0;
      decay_down_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      slew_down_out <= going_down && !wdata_in[PSCB_BIT_DECAY];
      decay_down_out <= going_down && wdata_in[PSCB_BIT_DECAY];
    end
  end
  assign ctrl_out = ctrl;
endmodule : pscb_ctrl_reg

// file: pscb_bank.sv
// Purpose: Status, shutdown cause and buck control register bank
// Assumes: Register port is decoded upstream from the serial host link
// Notes: Read data is registered, valid one cycle after the read strobe
// Function
// - Bit 0 of status shows die hot
// - Device sets cause flags; host writes one clears
// - Cold-off cause flag never set, reads zero
// - Supply undervoltage shutdown sets cause bit 2
// - Unmasked rail fault shutdown sets cause bit 1
// - Record faulting rails at 0xB2 and 0xB3
// - Critical temperature shutdown sets cause bit 0
// - Any cause set also sets shutdown indicator
// - First controller code from bits 7:1
// - Second controller code from bits 7:1
// - Decay bit zero: actively slew down
// - Decay bit one: passive decay down
// - Shutdown indicator bit 3, write one clears
// - Indicator held while any cause remains set
`timescale 1ns/1ps
module pscb_bank #(
  parameter logic [7:0] CTRL1_RESET = 8'h00,
  parameter logic [7:0] CTRL2_RESET = 8'h00,
  parameter logic [7:0] CTRL3_RESET = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input pscb_pkg::pscb_req_t req_in,
  input pscb_pkg::pscb_event_t event_in,
  input wire logic die_hot_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output pscb_pkg::pscb_ctrl_t first_ctrl_out,
  output pscb_pkg::pscb_ctrl_t second_ctrl_out,
  output logic first_slew_down_out,
  output logic first_decay_down_out,
  output logic second_slew_down_out,
  output logic second_decay_down_out,
  output logic third_decay_mode_out,
  output logic shutdown_event_indicator_out
);
  import pscb_pkg::*;

  // Address match used by the write decoder; the read mux decodes in its own case
  function automatic logic addr_is(input pscb_req_t r, input logic [7:0] a);
    addr_is = (r.addr == a);
  endfunction : addr_is

  function automatic logic wr_hit(input pscb_req_t r, input logic [7:0] a);
    wr_hit = r.wr && addr_is(r, a);
  endfunction : wr_hit

  // One flag placed in an otherwise zero byte; reserved bits read zero
  function automatic logic [7:0] lone_bit(input logic v, input int pos);
    lone_bit = PSCB_ZERO8;
    lone_bit[pos] = v;
  endfunction : lone_bit

  logic [PSCB_CAUSE_W-1:0] shutdown_cause;
  logic [PSCB_CAUSE_W-1:0] next_cause;
  logic [PSCB_CAUSE_W-1:0] cause_set;
  logic [PSCB_CAUSE_W-1:0] cause_clr;

  logic shdn_evt;
  logic next_shdn_evt;
  logic evt_clr_req;
  logic any_cause_set;
  logic any_cause_left;

  logic [PSCB_MAP_W-1:0] fault_map;
  logic [PSCB_MAP_W-1:0] next_fault_map;
  logic [7:0] third_ctrl;
  logic [7:0] next_third_ctrl;

  logic [7:0] read_mux;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic wr_c1;
  logic wr_c2;
  logic wr_c3;
  logic wr_cause;
  logic wr_irq;

  logic [7:0] die_temp_byte;
  logic [7:0] cause_byte;
  logic [7:0] irq_byte;
  logic [7:0] fault_lo_byte;
  logic [7:0] fault_hi_byte;
  pscb_ctrl_t c1;
  pscb_ctrl_t c2;

  // Register write strobes
  assign wr_c1 = wr_hit(req_in, PSCB_ADDR_CTRL1);
  assign wr_c2 = wr_hit(req_in, PSCB_ADDR_CTRL2);
  assign wr_c3 = wr_hit(req_in, PSCB_ADDR_CTRL3);
  assign wr_cause = wr_hit(req_in, PSCB_ADDR_SHDN_CAUSE);
  assign wr_irq = wr_hit(req_in, PSCB_ADDR_IRQ);

  assign cause_set[PSCB_BIT_CRIT] = event_in.critical_heat;
  assign cause_set[PSCB_BIT_RAIL] = event_in.rail_fault;
  assign cause_set[PSCB_BIT_UV] = event_in.supply_undervoltage;
  assign cause_set[PSCB_BIT_COLD] = 1'b0;
  // Only ones clear; zeros leave flags alone
  assign cause_clr = wr_cause ? req_in.wdata[PSCB_CAUSE_W-1:0] : PSCB_ZERO4;
  // Set beats a same-cycle clear so no shutdown is lost
  assign next_cause = cause_set | (shutdown_cause & ~cause_clr);

  assign any_cause_set = |cause_set;
  assign any_cause_left = |next_cause;
  assign evt_clr_req = wr_irq && req_in.wdata[PSCB_BIT_SHDN_EVT];
  // Clear refused while any cause stays pending; host clears causes first
  assign next_shdn_evt = any_cause_set || any_cause_left || (shdn_evt && !evt_clr_req);

  // Rail map captured with the fault shutdown, kept until the next one
  assign next_fault_map = event_in.rail_fault ? event_in.rail_fault_map : fault_map;
  // Third controller kept as a plain byte; only its decay bit drives a bank output port, the whole byte reads back at 0x22
  assign next_third_ctrl = wr_c3 ? req_in.wdata : third_ctrl;

  // Hot flag is a level from the sensor path, read live
  assign die_temp_byte = lone_bit(die_hot_in, PSCB_BIT_DIE_HOT);
  assign cause_byte = 8'(shutdown_cause);
  assign irq_byte = lone_bit(shdn_evt, PSCB_BIT_SHDN_EVT);
  assign fault_lo_byte = fault_map[PSCB_BYTE_W-1:0];
  assign fault_hi_byte = fault_map[PSCB_MAP_W-1:PSCB_BYTE_W];

  always_comb begin
    read_mux = PSCB_ZERO8;
    case (req_in.addr)
      PSCB_ADDR_DIE_TEMP: read_mux = die_temp_byte;
      PSCB_ADDR_SHDN_CAUSE: read_mux = cause_byte;
      PSCB_ADDR_IRQ: read_mux = irq_byte;
      PSCB_ADDR_CTRL1: read_mux = c1;
      PSCB_ADDR_CTRL2: read_mux = c2;
      PSCB_ADDR_CTRL3: read_mux = third_ctrl;
      PSCB_ADDR_FAULT1: read_mux = fault_lo_byte;
      PSCB_ADDR_FAULT2: read_mux = fault_hi_byte;
      default: read_mux = PSCB_ZERO8;
    endcase
  end

  // Read data holds until the next read; unmapped reads give zero
  assign next_rdata = req_in.rd ? read_mux : rdata_out;
  assign next_rvalid = req_in.rd;

  // Synchronous reset on every register
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      shutdown_cause <= PSCB_CAUSE_RESET;
    end else begin
      shutdown_cause <= next_cause;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      shdn_evt <= 1'b0;
    end else begin
      shdn_evt <= next_shdn_evt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      fault_map <= PSCB_ZERO16;
    end else begin
      fault_map <= next_fault_map;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      third_ctrl <= CTRL3_RESET;
    end else begin
      third_ctrl <= next_third_ctrl;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= PSCB_ZERO8;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= next_rvalid;
    end
  end

  pscb_ctrl_reg #(.RESET_VALUE(CTRL1_RESET)) u_first (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_c1),
    .wdata_in(req_in.wdata),
    .ctrl_out(c1),
    .slew_down_out(first_slew_down_out),
    .decay_down_out(first_decay_down_out)
  );

  pscb_ctrl_reg #(.RESET_VALUE(CTRL2_RESET)) u_second (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_c2),
    .wdata_in(req_in.wdata),
    .ctrl_out(c2),
    .slew_down_out(second_slew_down_out),
    .decay_down_out(second_decay_down_out)
  );

  assign first_ctrl_out = c1;
  assign second_ctrl_out = c2;
  assign third_decay_mode_out = third_ctrl[PSCB_BIT_DECAY];
  assign shutdown_event_indicator_out = shdn_evt;
endmodule : pscb_bank

// file: pscb_bank_checker.sv
// Purpose: Bank port assertions
// Assumes: One clock
// Notes: Bound to each bank
`timescale 1ns/1ps
module pscb_bank_checker (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input pscb_pkg::pscb_req_t req_in,
  input pscb_pkg::pscb_event_t event_in,
  input wire logic die_hot_in,
  input wire logic [7:0] rdata_out,
  input pscb_pkg::pscb_ctrl_t first_ctrl_out,
  input wire logic first_slew_down_out,
  input wire logic first_decay_down_out,
  input wire logic shutdown_event_indicator_out);
  import pscb_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire w1 = req_in.wr && req_in.addr == PSCB_ADDR_CTRL1;
  wire dn = w1 && req_in.wdata[7:1] < first_ctrl_out.code;
  wire ind = shutdown_event_indicator_out;
  AST_DIE: assert property (req_in.rd && req_in.addr == 8'h04 |=> rdata_out == {7'h00, $past(die_hot_in)})
    else $error("bad status");
  AST_COLD: assert property (req_in.rd && req_in.addr == 8'h05 |=> rdata_out[7:3] == 5'h00)
    else $error("bad cause");
  AST_EVT: assert property (event_in[18:16] != 3'h0 |=> ind) else $error("no shutdown");
  AST_HOLD: assert property (ind && !(req_in.wr && req_in.addr == 8'h02) |=> ind) else $error("lost");
  AST_CODE: assert property (w1 |=> first_ctrl_out == $past(req_in.wdata)) else $error("bad code");
  AST_SLEW: assert property (dn && !req_in.wdata[0] |=> first_slew_down_out && !first_decay_down_out)
    else $error("no slew");
  AST_DECAY: assert property (dn && req_in.wdata[0] |=> first_decay_down_out && !first_slew_down_out)
    else $error("no decay");
  AST_NODN: assert property (w1 && !dn |=> !first_slew_down_out && !first_decay_down_out)
    else $error("stray");
  cover property (dn);
  cover property (dn && req_in.wdata[0]);
  cover property (ind && req_in.wr);
  cover property (event_in[17]);
endmodule : pscb_bank_checker
bind pscb_bank pscb_bank_checker i_chk (.*);

// file: pscb_host_model.sv
// Purpose: Host side of register port
// Assumes: Called just after a rising edge
// Notes: Released fields show inverted values
`timescale 1ns/1ps
module pscb_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output pscb_pkg::pscb_req_t req_out);
  import pscb_pkg::*;
  initial req_out = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
    req_out <= '{w, !w, a, v};
    @(posedge ref_clk_in);
    req_out <= '{1'b0, 1'b0, ~a, ~v};
    @(posedge ref_clk_in);
    q = rvalid_in ? rdata_in : 8'hXX;
  endtask : xfer
endmodule : pscb_host_model

// file: tb_pscb_bank.sv
// Purpose: Self-checking bank bench
// Assumes: Host model drives requests
// Notes: Expected map is an int array
`timescale 1ns/1ps
module tb_pscb_bank;
  import pscb_pkg::*;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, hot = 1'b0, rv, s1, y1, s2, y2, t3, ind;
  pscb_req_t req;
  pscb_event_t ev = '0;
  pscb_ctrl_t c1o, c2o;
  logic [7:0] rd, d;
  logic [7:0] adr[9] = '{8'h04, 8'h05, 8'h02, 8'h20, 8'h21, 8'h22, 8'hB2, 8'hB3, 8'h7F};
  int seed = 32'heca363a3, miscompares = 0, check_count = 0, w, e, i, m[256] = '{default: 0};
  always #5 ref_clk_in = ~ref_clk_in;
  pscb_bank i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req), .event_in(ev), .die_hot_in(hot),
    .rdata_out(rd), .rvalid_out(rv), .first_ctrl_out(c1o), .second_ctrl_out(c2o), .first_slew_down_out(s1),
    .first_decay_down_out(y1), .second_slew_down_out(s2), .second_decay_down_out(y2), .third_decay_mode_out(t3),
    .shutdown_event_indicator_out(ind));
  pscb_host_model i_host (.ref_clk_in(ref_clk_in), .rdata_in(rd), .rvalid_in(rv), .req_out(req));
  task automatic tally(input logic bad, input string what);
    check_count++;
    if (bad) begin
      miscompares++;
      $display("Error %0t: %s", $time, what);
    end
  endtask : tally
  task automatic cmp_read(input logic [7:0] a, input logic [7:0] g, input logic [7:0] x);
    tally(g !== x, $sformatf("read %h got %h want %h", a, g, x));
  endtask : cmp_read
  task automatic cmp_move(input logic [3:0] g, input logic [3:0] x);
    tally(g !== x, $sformatf("down moves got %b want %b", g, x));
  endtask : cmp_move
  task automatic cmp_level(input logic [7:0] g, input logic [7:0] x);
    tally(g !== x, $sformatf("output level got %h want %h", g, x));
  endtask : cmp_level
  task automatic chk_all();
    cmp_level(c1o, 8'(m[32]));
    cmp_level(c2o, 8'(m[33]));
    cmp_level({6'h00, t3, ind}, {6'h00, m[34][0], m[2][3]});
    for (int k = 0; k < 9; k++) begin
      i_host.xfer(1'b0, adr[k], 8'h00, d);
      cmp_read(adr[k], d, 8'(m[adr[k]]));
    end
  endtask : chk_all
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    chk_all();
    $display("reset done");
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      // Force the first and second controllers through one slew and one decay move
      if (i % 12 < 2) w[7:1] = 7'h7F;
      if (i % 12 == 6 || i % 12 == 7) w[0] = i > 12;
      hot <= w[8];
      m[4] = w[8];
      i_host.xfer(1'b1, adr[3 + i % 6], w[7:0], d);
      e = 0;
      if (i % 6 < 2 && w[7:1] < m[32 + i % 6][7:1]) e = (w[0] ? 1 : 2) << (2 - 2 * (i % 6));
      cmp_move({s1, y1, s2, y2}, 4'(e));
      if (i % 6 < 3) m[32 + i % 6] = w[7:0];
    end
    chk_all();
    $display("control done");
    for (i = 0; i < 3; i++) begin
      w = $random(seed);
      ev <= {3'(4 >> i), w[15:0]};
      m[5] |= 1 << i;
      if (i == 1) m[8'hB2] = w[7:0];
      if (i == 1) m[8'hB3] = w[15:8];
      @(posedge ref_clk_in);
    end
    ev <= '0;
    m[2] = 8;
    i_host.xfer(1'b1, 8'h05, 8'hF0, d);
    i_host.xfer(1'b1, 8'h02, 8'h08, d);
    chk_all();
    for (i = 0; i < 3; i++) i_host.xfer(1'b1, 8'h05, 8'(1 << i), d);
    m[5] = 0;
    i_host.xfer(1'b1, 8'h02, 8'h08, d);
    m[2] = 0;
    chk_all();
    $display("cause done");
    // Mid-run reset with a fresh cause pending must clear every register
    ev <= {3'h4, 16'hFFFF};
    @(posedge ref_clk_in);
    ev <= '0;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    foreach (adr[k]) if (adr[k] != 8'h04) m[adr[k]] = 0;
    chk_all();
    $display("rerun reset done");
    give_verdict();
  end
endmodule : tb_pscb_bank
